// *** verilog/sfs_defines.svh ***
// Constants for the serial flash slave: opcodes, status layout, timing
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH

`define SFS_OP_SET_WEN        8'h06
`define SFS_OP_CLR_WEN        8'h04
`define SFS_OP_RD_STATUS      8'h05
`define SFS_OP_WR_STATUS      8'h01
`define SFS_OP_READ           8'h03
`define SFS_OP_WRITE          8'h02
`define SFS_OP_SECTOR_ERASE   8'h20
`define SFS_OP_ARRAY_ERASE    8'h60

`define SFS_OPCODE_BITS       5'h08
`define SFS_STATUS_BITS       5'h08
`define SFS_ST_BUSY_BIT       0
`define SFS_ST_WEN_BIT        1
`define SFS_ST_BP_LO_BIT      2
`define SFS_ST_BP_HI_BIT      3
`define SFS_STATUS_RESET      8'h00

`define SFS_ARRAY_WORDS       512
`define SFS_SECTOR_WORDS      10'h100
`define SFS_ARRAY_END         10'h200
`define SFS_BASE_LAST_ADDR    9'h0ff
`define SFS_ERASED_WORD       16'hffff

`define SFS_CLK_PERIOD_NS     10
`define SFS_WRITE_TIME_US     110
`define SFS_SECTOR_ERASE_MS   501
`define SFS_FULL_ERASE_MS     1002
`define SFS_WRITE_CYCLES      ((`SFS_WRITE_TIME_US * 1000) / `SFS_CLK_PERIOD_NS)
`define SFS_SECTOR_CYCLES     ((`SFS_SECTOR_ERASE_MS * 1000000) / `SFS_CLK_PERIOD_NS)
`define SFS_FULL_CYCLES       ((`SFS_FULL_ERASE_MS * 1000000) / `SFS_CLK_PERIOD_NS)

`endif

// *** verilog/sfs_pkg.sv ***
// Types shared by the serial flash slave modules
`default_nettype none
package sfs_pkg;

	typedef enum logic [2:0] {
		ST_IDLE       = 3'h0,
		ST_OPCODE     = 3'h1,
		ST_ADDR       = 3'h2,
		ST_RDATA      = 3'h3,
		ST_WDATA      = 3'h4,
		ST_STATUS_OUT = 3'h5,
		ST_STATUS_IN  = 3'h6,
		ST_WAIT       = 3'h7
	} sfs_state_e;

	typedef enum logic [1:0] {
		FOP_WRITE     = 2'h0,
		FOP_ERASE_S0  = 2'h1,
		FOP_ERASE_S1  = 2'h2,
		FOP_ERASE_ALL = 2'h3
	} sfs_fop_e;

	typedef struct packed {
		logic        start;
		sfs_fop_e    op;
		logic [8:0]  addr;
		logic [15:0] wdata;
	} sfs_flash_cmd_s;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
	} sfs_pins_s;

endpackage
`default_nettype wire

// *** verilog/sfs_sync.sv ***
// Two-stage synchroniser, one chain per bit
`default_nettype none
module sfs_sync #(
	parameter int          W       = 3,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_sys_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic meta_reg;
		logic sync_reg;
		always_ff @(posedge clk_sys_i) begin
			if (srst_i) begin
				meta_reg <= RST_VAL[i];
				sync_reg <= RST_VAL[i];
			end else begin
				meta_reg <= d_i[i];
				sync_reg <= meta_reg;
			end
		end
		assign q_o[i] = sync_reg;
	end
endmodule // sfs_sync
`default_nettype wire

// *** verilog/sfs_flash_array.sv ***
// User flash array with self-timed program and erase cycles
`include "sfs_defines.svh"
`default_nettype none
module sfs_flash_array import sfs_pkg::*; #(
	parameter int WRITE_CYCLES  = `SFS_WRITE_CYCLES,
	parameter int SECTOR_CYCLES = `SFS_SECTOR_CYCLES,
	parameter int FULL_CYCLES   = `SFS_FULL_CYCLES
) (
	input  wire logic           clk_sys_i,
	input  wire logic           srst_i,
	input  wire sfs_flash_cmd_s cmd_i,
	input  wire logic [8:0]     raddr_i,
	output logic      [15:0]    rdata_o,
	output logic                busy_o
);
	logic [15:0] mem [0:`SFS_ARRAY_WORDS-1];
	logic [31:0] timer_reg;
	logic [9:0]  ptr_reg;
	logic [9:0]  end_reg;
	logic        erase_reg;
	logic        take;
	logic        walking;

	assign take    = cmd_i.start && !busy_o;
	assign walking = busy_o && erase_reg && (ptr_reg != end_reg);

	// Erase walks one word per cycle, far shorter than the timed cycle
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			busy_o    <= 1'b0;
			timer_reg <= 32'h0;
			ptr_reg   <= 10'h000;
			end_reg   <= 10'h000;
			erase_reg <= 1'b0;
		end else if (take) begin
			busy_o    <= 1'b1;
			erase_reg <= (cmd_i.op != FOP_WRITE);
			ptr_reg   <= (cmd_i.op == FOP_ERASE_S1) ? `SFS_SECTOR_WORDS : 10'h000;
			end_reg   <= (cmd_i.op == FOP_ERASE_S0) ? `SFS_SECTOR_WORDS : `SFS_ARRAY_END;
			case (cmd_i.op)
				FOP_WRITE:     timer_reg <= 32'(WRITE_CYCLES);
				FOP_ERASE_ALL: timer_reg <= 32'(FULL_CYCLES);
				default:       timer_reg <= 32'(SECTOR_CYCLES);
			endcase
		end else if (busy_o) begin
			if (timer_reg != 32'h0)
				timer_reg <= timer_reg - 32'h1;
			if (walking)
				ptr_reg <= ptr_reg + 10'h001;
			if (timer_reg == 32'h0 && !walking)
				busy_o <= 1'b0;
		end
	end

	// Programming can only clear bits, as in real flash
	always_ff @(posedge clk_sys_i) begin
		if (take && cmd_i.op == FOP_WRITE)
			mem[cmd_i.addr] <= mem[cmd_i.addr] & cmd_i.wdata;
		else if (walking)
			mem[ptr_reg[8:0]] <= `SFS_ERASED_WORD;
		rdata_o <= mem[raddr_i];
	end
endmodule // sfs_flash_array
`default_nettype wire

// *** verilog/sfs_spi_slave.sv ***
// Serial peripheral slave in front of the user flash array
// Summary of operation
// - Base 8-bit words, extended 16-bit words
// - Base uses sector 0, extended both sectors
// - Sample serial input on clock rise
// - Launch serial output on clock fall
// - Low chip select alone qualifies transfers
// - Deselected: ignore inputs, output high impedance
// - Frames start at select low, MSB first
// - Unknown opcode: ignore rest of frame
// - Select high returns to idle decoding
// - Opcodes 06 set, 04 clear write enable
// - Opcodes 05 read, 01 write status
// - Opcodes 03 read, 02 write array
// - Opcodes 20 sector, 60 whole erase
// - Status bit 0 shows busy cycle
// - Status bit 1 shows write enable
// - Status bits 3:2 hold protect level
// - Read-only build has no status register
// - Oscillator enable held permanently asserted
// - Extended address drops first seven bits
// - Write only if enabled and unprotected
// - Busy refuses read and write opcodes
// - Program or erase starts at select rise
`include "sfs_defines.svh"
`default_nettype none
module sfs_spi_slave import sfs_pkg::*; #(
	parameter bit EXTENDED      = 1'b1,
	parameter bit READ_ONLY     = 1'b0,
	parameter int WRITE_CYCLES  = `SFS_WRITE_CYCLES,
	parameter int SECTOR_CYCLES = `SFS_SECTOR_CYCLES,
	parameter int FULL_CYCLES   = `SFS_FULL_CYCLES
) (
	input  wire logic       clk_sys_i,
	input  wire logic       srst_i,
	input  wire logic       chip_select_n_i,
	input  wire logic       spi_sck_i,
	input  wire logic       spi_si_i,
	output logic            spi_so_o,
	output logic            spi_so_oe_n_o,
	output logic [7:0]      status_o,
	output logic            oscillator_enable_o
);
	localparam int W = EXTENDED ? 16 : 8;

	sfs_pins_s      pins_s;
	sfs_state_e     state_reg;
	sfs_flash_cmd_s cmd_reg;
	logic           sck_d_reg;
	logic           cs_d_reg;
	logic [4:0]     bit_cnt_reg;
	logic [4:0]     phase_len;
	logic [15:0]    rx_sh_reg;
	logic [15:0]    rx_next;
	logic [15:0]    tx_sh_reg;
	logic [15:0]    tx_src;
	logic [7:0]     op_reg;
	logic [8:0]     addr_reg;
	logic [8:0]     addr_in;
	logic [15:0]    rdata;
	logic           flash_busy;
	logic           wen_reg;
	logic [1:0]     bp_reg;
	logic           pend_reg;
	logic           tx_load_reg;
	logic           rd_end_reg;
	logic           sck_rise;
	logic           sck_fall;
	logic           cs_rise;
	logic           bit_done;
	logic           word_start;
	logic           op_known;
	logic           erase_ok;

	// master clock arrives as a pin
	sfs_sync #(
		.W       (3),
		.RST_VAL (3'b100)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.srst_i    (srst_i),
		.d_i       ({chip_select_n_i, spi_sck_i, spi_si_i}),
		.q_o       (pins_s)
	);

	sfs_flash_array #(
		.WRITE_CYCLES  (WRITE_CYCLES),
		.SECTOR_CYCLES (SECTOR_CYCLES),
		.FULL_CYCLES   (FULL_CYCLES)
	) u_array (
		.clk_sys_i (clk_sys_i),
		.srst_i    (srst_i),
		.cmd_i     (cmd_reg),
		.raddr_i   (addr_reg),
		.rdata_o   (rdata),
		.busy_o    (flash_busy)
	);

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			sck_d_reg <= 1'b0;
			cs_d_reg  <= 1'b1;
		end else begin
			sck_d_reg <= pins_s.sck;
			cs_d_reg  <= pins_s.cs_n;
		end
	end

	assign sck_rise = pins_s.sck && !sck_d_reg;
	assign sck_fall = !pins_s.sck && sck_d_reg;
	assign cs_rise  = pins_s.cs_n && !cs_d_reg;
	assign rx_next  = {rx_sh_reg[14:0], pins_s.si};
	// keep the low nine address bits; base keeps the low eight with the ninth zero
	assign addr_in  = EXTENDED ? rx_next[8:0] : {1'b0, rx_next[7:0]};

	always_comb begin
		case (state_reg)
			ST_OPCODE:                        phase_len = `SFS_OPCODE_BITS;
			ST_STATUS_OUT, ST_STATUS_IN:      phase_len = `SFS_STATUS_BITS;
			ST_ADDR, ST_RDATA, ST_WDATA:      phase_len = 5'(W);
			default:                          phase_len = 5'h00;
		endcase
	end

	// only a selected device counts bits
	assign bit_done = sck_rise && !pins_s.cs_n && (phase_len != 5'h00) &&
		(bit_cnt_reg == phase_len - 5'h01);

	function automatic logic protected_addr(input logic [8:0] a, input logic [1:0] bp);
		logic [1:0] top;
		top = EXTENDED ? a[8:7] : a[7:6];
		return (bp == 2'h3) || (bp == 2'h2 && top[1]) || (bp == 2'h1 && top == 2'h3);
	endfunction

	function automatic sfs_state_e op_next(input logic [7:0] op, input logic busy);
		case (op)
			`SFS_OP_SET_WEN, `SFS_OP_CLR_WEN, `SFS_OP_ARRAY_ERASE: op_next = ST_WAIT;
			`SFS_OP_RD_STATUS:    op_next = READ_ONLY ? ST_WAIT : ST_STATUS_OUT;
			`SFS_OP_WR_STATUS:    op_next = READ_ONLY ? ST_WAIT : ST_STATUS_IN;
			`SFS_OP_READ:         op_next = busy ? ST_WAIT : ST_ADDR;
			`SFS_OP_WRITE:        op_next = (busy || READ_ONLY) ? ST_WAIT : ST_ADDR;
			`SFS_OP_SECTOR_ERASE: op_next = (busy || READ_ONLY || !EXTENDED) ? ST_WAIT : ST_ADDR;
			default:              op_next = ST_WAIT;
		endcase
	endfunction

	always_comb begin
		case (rx_next[7:0])
			`SFS_OP_SET_WEN, `SFS_OP_CLR_WEN, `SFS_OP_READ,
			`SFS_OP_SECTOR_ERASE, `SFS_OP_ARRAY_ERASE: op_known = 1'b1;
			`SFS_OP_RD_STATUS, `SFS_OP_WR_STATUS, `SFS_OP_WRITE: op_known = !READ_ONLY;
			default: op_known = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			rx_sh_reg <= 16'h0000;
		else if (sck_rise && !pins_s.cs_n)
			rx_sh_reg <= rx_next;
	end

	// Sequencer for one frame
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state_reg   <= ST_IDLE;
			bit_cnt_reg <= 5'h00;
			op_reg      <= 8'h00;
			addr_reg    <= 9'h000;
			rd_end_reg  <= 1'b0;
		end else if (pins_s.cs_n) begin
			state_reg   <= ST_IDLE;
			bit_cnt_reg <= 5'h00;
			rd_end_reg  <= 1'b0;
		end else if (state_reg == ST_IDLE) begin
			state_reg   <= ST_OPCODE;
			bit_cnt_reg <= 5'h00;
		end else if (sck_rise) begin
			bit_cnt_reg <= bit_done ? 5'h00 : bit_cnt_reg + 5'h01;
			if (bit_done) begin
				case (state_reg)
					ST_OPCODE: begin
						op_reg    <= rx_next[7:0];
						state_reg <= op_next(rx_next[7:0], flash_busy);
					end
					ST_ADDR: begin
						addr_reg <= addr_in;
						// write data phase needs enable and an unprotected address; read data phase always follows
						if (op_reg == `SFS_OP_READ)
							state_reg <= ST_RDATA;
						else if (op_reg == `SFS_OP_WRITE && wen_reg && !protected_addr(addr_in, bp_reg))
							state_reg <= ST_WDATA;
						else
							state_reg <= ST_WAIT;
					end
					ST_RDATA: begin
						// base stops at sector end, extended wraps
						if (!EXTENDED && addr_reg == `SFS_BASE_LAST_ADDR)
							rd_end_reg <= 1'b1;
						else
							addr_reg <= addr_reg + 9'h001;
					end
					ST_WDATA, ST_STATUS_IN: state_reg <= ST_WAIT;
					default:                state_reg <= state_reg;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || READ_ONLY) begin
			wen_reg <= 1'b0;
			bp_reg  <= 2'h0;
		end else if (bit_done && state_reg == ST_OPCODE) begin
			// enable pair acts on status only
			if (rx_next[7:0] == `SFS_OP_SET_WEN)
				wen_reg <= 1'b1;
			else if (rx_next[7:0] == `SFS_OP_CLR_WEN)
				wen_reg <= 1'b0;
		end else if (bit_done && state_reg == ST_STATUS_IN && wen_reg) begin
			// upper bits and enable bit not writable
			bp_reg <= rx_next[`SFS_ST_BP_HI_BIT:`SFS_ST_BP_LO_BIT];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || READ_ONLY)
			status_o <= `SFS_STATUS_RESET;
		else
			status_o <= {4'h0, bp_reg, wen_reg, flash_busy};
	end

	// Sector erase checks depend on which sector and level
	always_comb begin
		if (!wen_reg || flash_busy || READ_ONLY)
			erase_ok = 1'b0;
		else if (state_reg == ST_ADDR)
			erase_ok = addr_in[8] ? (bp_reg == 2'h0) : (bp_reg != 2'h3);
		else
			erase_ok = (bp_reg == 2'h0);
	end

	// queue work, release it at select rise
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			pend_reg <= 1'b0;
			cmd_reg  <= '0;
		end else if (cs_rise) begin
			cmd_reg.start <= pend_reg;
			pend_reg      <= 1'b0;
		end else begin
			cmd_reg.start <= 1'b0;
			if (bit_done && state_reg == ST_WDATA) begin
				pend_reg      <= 1'b1;
				cmd_reg.op    <= FOP_WRITE;
				cmd_reg.addr  <= addr_reg;
				cmd_reg.wdata <= EXTENDED ? rx_next : {8'hff, rx_next[7:0]};
			end else if (bit_done && state_reg == ST_ADDR && op_reg == `SFS_OP_SECTOR_ERASE && erase_ok) begin
				// extended sector picked by ninth bit
				pend_reg   <= 1'b1;
				cmd_reg.op <= addr_in[8] ? FOP_ERASE_S1 : FOP_ERASE_S0;
			end else if (bit_done && state_reg == ST_OPCODE && erase_ok &&
				(rx_next[7:0] == `SFS_OP_ARRAY_ERASE ||
				(!EXTENDED && rx_next[7:0] == `SFS_OP_SECTOR_ERASE))) begin
				pend_reg   <= 1'b1;
				cmd_reg.op <= EXTENDED ? FOP_ERASE_ALL : FOP_ERASE_S0;
			end
		end
	end

	// A new word is fetched at the end of each read or status word, and of the read header or status opcode
	assign word_start = bit_done && ((state_reg == ST_ADDR && op_reg == `SFS_OP_READ) ||
		state_reg == ST_RDATA || state_reg == ST_STATUS_OUT ||
		(state_reg == ST_OPCODE && op_next(rx_next[7:0], flash_busy) == ST_STATUS_OUT));
	// status rides in the top byte
	assign tx_src = (state_reg == ST_STATUS_OUT) ? {status_o, 8'h00} : (EXTENDED ? rdata : {rdata[7:0], 8'h00});

	// launch on fall, float when idle
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			spi_so_o      <= 1'b0;
			spi_so_oe_n_o <= 1'b1;
			tx_sh_reg     <= 16'h0000;
			tx_load_reg   <= 1'b0;
		end else if (pins_s.cs_n) begin
			spi_so_oe_n_o <= 1'b1;
			tx_load_reg   <= 1'b0;
		end else if (word_start) begin
			tx_load_reg <= 1'b1;
		end else if (sck_fall && (state_reg == ST_RDATA || state_reg == ST_STATUS_OUT)) begin
			if (rd_end_reg) begin
				spi_so_oe_n_o <= 1'b1;
			end else begin
				spi_so_oe_n_o <= 1'b0;
				tx_load_reg   <= 1'b0;
				spi_so_o      <= tx_load_reg ? tx_src[15] : tx_sh_reg[15];
				tx_sh_reg     <= tx_load_reg ? {tx_src[14:0], 1'b0} : {tx_sh_reg[14:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			oscillator_enable_o <= 1'b1;
		else
			oscillator_enable_o <= 1'b1;
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	sequence s_op_taken;
		bit_done && state_reg == ST_OPCODE;
	endsequence

	sequence s_set_write_enable_op_taken;
		s_op_taken ##0 (!READ_ONLY && rx_next[7:0] == `SFS_OP_SET_WEN);
	endsequence

	property p_set_write_enable_op_sets;
		s_set_write_enable_op_taken |-> ##[1:2] status_o[`SFS_ST_WEN_BIT];
	endproperty
	a_set_write_enable_op_sets: assert property (p_set_write_enable_op_sets) else $error("write enable not set");

	property p_bad_op_waits;
		s_op_taken ##0 !op_known |=> (state_reg == ST_WAIT) until pins_s.cs_n;
	endproperty
	a_bad_op_waits: assert property (p_bad_op_waits) else $error("unknown opcode not ignored");

	property p_busy_refuse;
		s_op_taken ##0 (flash_busy && (rx_next[7:0] == `SFS_OP_READ || rx_next[7:0] == `SFS_OP_WRITE))
			|=> state_reg == ST_WAIT;
	endproperty
	a_busy_refuse: assert property (p_busy_refuse) else $error("busy did not refuse access");

	property p_write_gate;
		bit_done && state_reg == ST_ADDR && op_reg == `SFS_OP_WRITE && !wen_reg |=> state_reg == ST_WAIT;
	endproperty
	a_write_gate: assert property (p_write_gate) else $error("write accepted while disabled");

	property p_hiz_deselect;
		pins_s.cs_n |=> spi_so_oe_n_o;
	endproperty
	a_hiz_deselect: assert property (p_hiz_deselect) else $error("output driven while deselected");

	property p_status_top_zero;
		status_o[7:4] == 4'h0;
	endproperty
	a_status_top_zero: assert property (p_status_top_zero) else $error("status upper bits not zero");

	property p_osc_on;
		oscillator_enable_o;
	endproperty
	a_osc_on: assert property (p_osc_on) else $error("oscillator enable dropped");

	property p_start_at_rise;
		cmd_reg.start |-> $past(cs_rise);
	endproperty
	a_start_at_rise: assert property (p_start_at_rise) else $error("flash cycle started inside frame");

	property p_busy_shown;
		cmd_reg.start && !flash_busy |-> ##[2:3] status_o[`SFS_ST_BUSY_BIT] || READ_ONLY;
	endproperty
	a_busy_shown: assert property (p_busy_shown) else $error("busy flag not raised");

	property p_launch_on_fall;
		$changed(spi_so_o) |-> $past(sck_fall);
	endproperty
	a_launch_on_fall: assert property (p_launch_on_fall) else $error("output changed off falling edge");

	property p_sample_on_rise;
		$changed(rx_sh_reg) |-> $past(sck_rise);
	endproperty
	a_sample_on_rise: assert property (p_sample_on_rise) else $error("input sampled off rising edge");
endmodule // sfs_spi_slave
`default_nettype wire

// *** verification/sfs_spi_master_model.sv ***
// Behavioural SPI bus master that drives the slave's select, clock and data pins
`default_nettype none
module sfs_spi_master_model import sfs_pkg::*; (
	input  wire logic clk_sys_i,
	input  wire logic so_i,
	output var sfs_pins_s pins_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// master owns the clock; it stands low outside frames
	initial pins_o = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	// frame opens at select fall, MSB first, opcode first
	// data set while clock low, read back at the clock rise
	task automatic xfer(input logic [63:0] tx, input int nb, output logic [63:0] rx);
		rx = '0;
		tick(6);
		pins_o.cs_n <= 1'b0;
		tick(4);
		for (int i = nb - 1; i >= 0; i--) begin
			pins_o.si <= tx[i];
			tick(4);
			pins_o.sck <= 1'b1;
			rx = {rx[62:0], so_i};
			tick(8);
			pins_o.sck <= 1'b0;
			tick(4);
		end
	endtask

	// select rises to end each request; released input shows the inverse
	task automatic release_cs();
		pins_o.cs_n <= 1'b1;
		pins_o.si   <= ~pins_o.si;
		tick(1);
	endtask
endmodule // sfs_spi_master_model
`default_nettype wire

// *** verification/spi_flash_slave_interface_tb.sv ***
// Self-checking bench for the serial flash slave
`default_nettype none
module spi_flash_slave_interface_tb import sfs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int WC = 20;
	logic        clk_sys_i;
	logic        srst_i;
	sfs_pins_s   pins;
	logic        spi_so;
	logic        so_oe_n;
	logic        osc_en;
	logic [7:0]  status;
	logic        ro_so;
	logic        ro_oe_n;
	logic        ro_osc;
	logic [7:0]  ro_status;
	wire         so_line;
	int          fails;
	int          n_tests;
	int          n;
	logic [63:0] rx;
	logic [8:0]  a;
	logic [15:0] d;
	logic [15:0] d0;
	logic [15:0] d1;
	int unsigned seed_v;

	// Released output floats; the master sees Z
	assign so_line = so_oe_n ? 1'bz : spi_so;

	sfs_spi_slave #(.EXTENDED(1'b1), .READ_ONLY(1'b0), .WRITE_CYCLES(WC), .SECTOR_CYCLES(600),
		.FULL_CYCLES(1200)) dut (
		.clk_sys_i          (clk_sys_i),
		.srst_i             (srst_i),
		.chip_select_n_i    (pins.cs_n),
		.spi_sck_i          (pins.sck),
		.spi_si_i           (pins.si),
		.spi_so_o           (spi_so),
		.spi_so_oe_n_o      (so_oe_n),
		.status_o           (status),
		.oscillator_enable_o(osc_en)
	);

	// Base read-only build listens on the same pins; it must never grow a status register
	sfs_spi_slave #(.EXTENDED(1'b0), .READ_ONLY(1'b1), .WRITE_CYCLES(WC), .SECTOR_CYCLES(600),
		.FULL_CYCLES(1200)) dut_ro (
		.clk_sys_i          (clk_sys_i),
		.srst_i             (srst_i),
		.chip_select_n_i    (pins.cs_n),
		.spi_sck_i          (pins.sck),
		.spi_si_i           (pins.si),
		.spi_so_o           (ro_so),
		.spi_so_oe_n_o      (ro_oe_n),
		.status_o           (ro_status),
		.oscillator_enable_o(ro_osc)
	);

	sfs_spi_master_model m (.clk_sys_i(clk_sys_i), .so_i(so_line), .pins_o(pins));

	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic final_report();
		$display("checks %0d failures %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Longest expected run is near 16k cycles
	initial begin
		repeat (90000) @(posedge clk_sys_i);
		fails++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		final_report();
	end

	task automatic chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			fails++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic frame(input logic [63:0] tx, input int nb);
		m.xfer(tx, nb, rx);
		m.release_cs();
	endtask

	// Counts busy cycles; a cycle that never starts within 10 clocks gives zero
	// Sampled on the falling edge so the flag is settled, not racing its launch edge
	task automatic busy_len(output int cnt);
		int k;
		cnt = 0;
		k = 0;
		while (status[0] !== 1'b1 && k < 10) begin
			@(negedge clk_sys_i);
			k++;
		end
		while (status[0] === 1'b1 && cnt < 5000) begin
			@(negedge clk_sys_i);
			cnt++;
		end
		if (cnt >= 5000)
			chk(1'b0, "busy never cleared");
	endtask

	// Upper seven address bits are junk on purpose
	task automatic write_word(input logic [8:0] wa, input logic [15:0] wd);
		logic [6:0] junk;
		junk = 7'($urandom_range(127));
		frame({24'h0, 8'h02, junk, wa, wd}, 40);
		busy_len(n);
	endtask

	task automatic read_word(input logic [8:0] wa, input logic [15:0] exp);
		logic [6:0] junk;
		junk = 7'($urandom_range(127));
		frame({24'h0, 8'h03, junk, wa, 16'h0}, 40);
		chk(rx[15:0] === exp, "read word mismatch");
	endtask

	initial begin
		fails = 0;
		n_tests = 0;
		srst_i = 1'b1;
		seed_v = $urandom(32'h6435);
		repeat (12) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk(status === 8'h00, "status after reset");
		chk(ro_osc === 1'b1, "read-only oscillator disabled");
		chk(so_oe_n === 1'b1, "output driven while idle");
		chk(osc_en === 1'b1, "oscillator disabled");
		frame({48'h0, 8'h05, 8'h00}, 16);
		chk(rx[7:0] === 8'h00, "status byte on serial out");
		write_word(9'h010, 16'h1234);
		chk(n === 0, "write ran without enable");
		frame({56'h0, 8'h06}, 8);
		chk(status === 8'h02, "enable not set");
		chk(ro_status === 8'h00, "read-only build grew status");
		frame({48'h0, 8'h05, 8'h00}, 16);
		chk(rx[7:0] === 8'h02, "status byte after enable");
		m.xfer({56'h0, 8'h60}, 8, rx);
		m.tick(8);
		chk(status[0] === 1'b0, "erase began before select rise");
		m.release_cs();
		busy_len(n);
		chk(n > 0, "array erase showed no busy");
		for (int i = 0; i < 6; i++) begin
			a = (i == 0) ? 9'h1ff : (i == 1) ? 9'h000 : 9'(i * 80 + $urandom_range(79) + 1);
			d = 16'($urandom);
			if (i == 0)
				d1 = d;
			if (i == 1)
				d0 = d;
			write_word(a, d);
			chk(n === WC + 1, "write busy length");
			read_word(a, d);
		end
		// Stream past the top wraps to word zero
		frame({8'h0, 8'h03, 7'h55, 9'h1ff, 32'h0}, 56);
		chk(rx[31:0] === {d1, d0}, "read stream wrap");
		frame({32'h0, 8'hff, 24'ha5a5a5}, 32);
		chk(rx[23:0] === 24'hzzzzzz, "unknown opcode answered");
		chk(status === 8'h02, "unknown opcode changed status");
		frame({40'h0, 8'h20, 7'h00, 9'h100}, 24);
		frame({24'h0, 8'h03, 16'h0000, 16'h0}, 40);
		chk(rx[15:0] === 16'hzzzz, "read accepted while busy");
		busy_len(n);
		read_word(9'h1ff, 16'hffff);
		read_word(9'h000, d0);
		frame({48'h0, 8'h01, 8'hff}, 16);
		chk(status === 8'h0e, "protect level write");
		write_word(9'h001, 16'h0000);
		chk(n === 0, "write into protected region");
		frame({48'h0, 8'h01, 8'h00}, 16);
		frame({56'h0, 8'h04}, 8);
		chk(status === 8'h00, "enable not cleared");
		chk(ro_status === 8'h00 && ro_osc === 1'b1, "read-only status or oscillator");
		final_report();
	end
endmodule // spi_flash_slave_interface_tb
`default_nettype wire
